//--- sp_pkg.sv
// Shared constants and types of the serial port block
package sp_pkg;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_BUF  = 8'h04;
  localparam logic [7:0] OFS_PWR  = 8'h08;
  localparam logic [7:0] OFS_BDR  = 8'h0C;
  localparam logic [7:0] OFS_BRL  = 8'h10;

  // Serial control register fields
  localparam int CTL_RI  = 0;
  localparam int CTL_TI  = 1;
  localparam int CTL_RB8 = 2;
  localparam int CTL_TB8 = 3;
  localparam int CTL_REN = 4;
  localparam int CTL_MLO = 6;
  localparam int CTL_MHI = 7;
  localparam int CTL_FE  = 8;

  // Power control register fields
  localparam int PWR_FCE = 6;
  localparam int PWR_DBL = 7;

  // Baud generator control register fields
  localparam int BDR_SYNC_BAUD_SOURCE = 0;
  localparam int BDR_SPD   = 1;
  localparam int BDR_RBCK  = 2;
  localparam int BDR_TBCK  = 3;
  localparam int BDR_BRR   = 4;

  // Reset values
  localparam logic [7:0] RST_BRL = 8'h00;

  // Cycle and tick counts
  localparam logic [3:0] TICK_LAST    = 4'hF;
  localparam logic [3:0] SAMPLE_POINT = 4'h7;
  localparam logic [3:0] M0_FIX_LAST  = 4'h5;
  localparam logic [3:0] M0_FIX_HALF  = 4'h2;
  localparam logic [3:0] M0_VAR_HALF  = 4'h7;
  localparam logic [3:0] M0_BIT_LAST  = 4'h7;
  localparam logic [3:0] FRAME_LAST8  = 4'h9;
  localparam logic [3:0] FRAME_LAST9  = 4'hA;
  localparam logic [2:0] PRESCALE_LAST = 3'h5;
  localparam logic [7:0] BRG_TOP      = 8'hFF;

  typedef enum logic [1:0] {
    MODE_SHIFT  = 2'b00,
    MODE_UART8  = 2'b01,
    MODE_UART9F = 2'b10,
    MODE_UART9V = 2'b11
  } sp_mode_t;

  typedef enum logic [1:0] {
    ENG_IDLE  = 2'b00,
    ENG_ASYNC = 2'b01,
    ENG_M0TX  = 2'b10,
    ENG_M0RX  = 2'b11
  } sp_eng_t;

  typedef enum logic {
    RX_IDLE  = 1'b0,
    RX_FRAME = 1'b1
  } sp_rx_t;

  typedef struct packed {
    sp_mode_t   mode;
    logic       ren;
    logic       tb8;
    logic       rb8;
    logic       ti;
    logic       ri;
    logic       fe;
    logic       dbl;
    logic       fce;
    logic       sync_baud_source;
    logic       prescale_bypass;
    logic       brr;
    logic       tbck;
    logic       rbck;
    logic [7:0] baud_reload_value;
  } sp_cfg_t;

  typedef struct packed {
    sp_cfg_t     cfg;
    logic [7:0]  rxbuf;
    logic        ap_valid;
    logic        ap_write;
    logic [7:0]  ap_addr;
    sp_eng_t     eng;
    logic [3:0]  tx_bit;
    logic [3:0]  tx_cnt;
    logic [10:0] tx_sh;
    sp_rx_t      rx;
    logic [3:0]  rx_bit;
    logic [3:0]  rx_cnt;
    logic [8:0]  rx_sh;
    logic        rx_prev;
    logic        txd;
    logic        rxd_o;
    logic        rxd_oe;
    logic [31:0] hrdata;
    logic        hready;
    logic        hresp;
    logic        irq;
  } sp_state_t;

  typedef struct packed {
    logic [2:0] pre;
    logic [7:0] cnt;
    logic       ovf;
  } sp_brg_st_t;

  typedef struct packed {
    logic phase;
    logic tick;
  } sp_tick_st_t;

endpackage : sp_pkg

//--- sp_brg.sv
// Internal 8-bit auto-reload baud generator with optional divide-by-6 prescale
`timescale 1ns/1ps
module sp_brg (
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic       run,
  input  wire logic       bypass,
  input  wire logic [7:0] reload,
  output logic            ovf
);
  sp_pkg::sp_brg_st_t s_r;
  sp_pkg::sp_brg_st_t s_nxt;
  logic               en;

  always_comb begin
    s_nxt     = s_r;
    s_nxt.ovf = 1'b0;
    en        = 1'b0;
    if (run) begin
      en = bypass || (s_r.pre == sp_pkg::PRESCALE_LAST);
      if (bypass || (s_r.pre == sp_pkg::PRESCALE_LAST)) begin
        s_nxt.pre = 3'h0;
      end else begin
        s_nxt.pre = s_r.pre + 3'h1;
      end
      if (en) begin
        if (s_r.cnt == sp_pkg::BRG_TOP) begin
          s_nxt.cnt = reload;
          s_nxt.ovf = 1'b1;
        end else begin
          s_nxt.cnt = s_r.cnt + 8'h01;
        end
      end
    end else begin
      s_nxt.pre = 3'h0;
      s_nxt.cnt = reload;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign ovf = s_r.ovf;
endmodule : sp_brg

//--- sp_tick.sv
// Turns a baud source pulse into the 16x sampling tick, halved unless doubled
`timescale 1ns/1ps
module sp_tick (
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic src,
  input  wire logic halve,
  output logic      tick
);
  sp_pkg::sp_tick_st_t s_r;
  sp_pkg::sp_tick_st_t s_nxt;

  always_comb begin
    s_nxt      = s_r;
    s_nxt.tick = 1'b0;
    if (src) begin
      if (halve) begin
        s_nxt.phase = ~s_r.phase;
        s_nxt.tick  = s_r.phase;
      end else begin
        s_nxt.tick = 1'b1;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign tick = s_r.tick;
endmodule : sp_tick

//--- sp_uart.sv
// Serial port top: AHB-Lite registers, shift-register mode and three UART modes
//
// What this block does
// - Two mode bits select shift, 8-bit, 9-bit modes
// - Timer source only modes 1,3; generator 0,1,3
// - Timer overflow gives baud; doubler doubles rate
// - Generator: 8-bit reload counter, optional /6 prescale
// - Generator counts only while its run bit set
// - Mode 0 rate fixed /6 or generator-derived
// - Mode 0: eight clocks out, byte LSB first
// - Mode 0 send: buffer write, then high, done
// - Mode 0 receive: eight samples, done flag, buffer
// - Mode 1: ten-bit frames, full duplex
// - Mode 1 stores received stop bit as ninth
// - Modes 2,3: eleven-bit frames with ninth bit
// - Ninth bit sent from, received into control
// - Async send starts on buffer write
// - Async receive starts on falling edge, enabled
// - Frame check only while its enable is set
// - Bad stop bit sets framing error flag
// - Mode 2 rate clock /32, or /16 doubled
// - Framing error stays until software clears it
// - Done flags form one request, software-cleared
`timescale 1ns/1ps
module sp_uart (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic        rxd_in,
  output logic             rxd_out,
  output logic             rxd_oe,
  output logic             txd_out,
  input  wire logic        tmr_ovf,
  output logic             serial_irq
);
  sp_pkg::sp_state_t s_r;
  sp_pkg::sp_state_t s_nxt;

  logic       brg_ovf;
  logic       tx_src;
  logic       rx_src;
  logic       tx_tick;
  logic       rx_tick;
  logic       m0_tick;
  logic [3:0] m0_last;
  logic [3:0] m0_half;
  logic [3:0] tx_last;
  logic [3:0] rx_last;
  logic       wr;
  logic       ctrl_wr;
  logic       buf_wr;
  logic       ri_after_wr;
  logic       tx_fin_ev;
  logic       m0rx_fin_ev;
  logic       rx_stop_ev;
  logic       rx_store;
  logic       tx_go;
  logic       rx_ninth;
  logic       async_mode;

  function automatic logic [31:0] reg_read(input sp_pkg::sp_state_t s, input logic [7:0] a);
    logic [31:0] d;
    d = 32'h0000_0000;
    case (a)
      sp_pkg::OFS_CTRL: begin
        d[sp_pkg::CTL_MHI:sp_pkg::CTL_MLO] = s.cfg.mode;
        d[sp_pkg::CTL_REN] = s.cfg.ren;
        d[sp_pkg::CTL_TB8] = s.cfg.tb8;
        d[sp_pkg::CTL_RB8] = s.cfg.rb8;
        d[sp_pkg::CTL_TI]  = s.cfg.ti;
        d[sp_pkg::CTL_RI]  = s.cfg.ri;
        d[sp_pkg::CTL_FE]  = s.cfg.fe;
      end
      sp_pkg::OFS_BUF: d[7:0] = s.rxbuf;
      sp_pkg::OFS_PWR: begin
        d[sp_pkg::PWR_DBL] = s.cfg.dbl;
        d[sp_pkg::PWR_FCE] = s.cfg.fce;
      end
      sp_pkg::OFS_BDR: begin
        d[sp_pkg::BDR_SYNC_BAUD_SOURCE] = s.cfg.sync_baud_source;
        d[sp_pkg::BDR_SPD]   = s.cfg.prescale_bypass;
        d[sp_pkg::BDR_RBCK]  = s.cfg.rbck;
        d[sp_pkg::BDR_TBCK]  = s.cfg.tbck;
        d[sp_pkg::BDR_BRR]   = s.cfg.brr;
      end
      sp_pkg::OFS_BRL: d[7:0] = s.cfg.baud_reload_value;
      default: d = 32'h0000_0000;
    endcase
    return d;
  endfunction : reg_read

  // Baud sources and tick streams
  sp_brg u_brg (
    .hclk    (hclk),
    .hresetn (hresetn),
    .run     (s_r.cfg.brr),
    .bypass  (s_r.cfg.prescale_bypass),
    .reload  (s_r.cfg.baud_reload_value),
    .ovf     (brg_ovf)
  );

  assign async_mode = (s_r.cfg.mode != sp_pkg::MODE_SHIFT);
  assign tx_src = (s_r.cfg.mode == sp_pkg::MODE_UART9F) ? 1'b1 :
                  ((async_mode && !s_r.cfg.tbck) ? tmr_ovf : brg_ovf);
  assign rx_src = (s_r.cfg.mode == sp_pkg::MODE_UART9F) ? 1'b1 :
                  ((async_mode && !s_r.cfg.rbck) ? tmr_ovf : brg_ovf);

  sp_tick u_tx_tick (
    .hclk    (hclk),
    .hresetn (hresetn),
    .src     (tx_src),
    .halve   (~s_r.cfg.dbl),
    .tick    (tx_tick)
  );

  sp_tick u_rx_tick (
    .hclk    (hclk),
    .hresetn (hresetn),
    .src     (rx_src),
    .halve   (~s_r.cfg.dbl),
    .tick    (rx_tick)
  );

  // Mode 0 shift timing and async frame lengths
  assign m0_tick = s_r.cfg.sync_baud_source ? tx_tick : 1'b1;
  assign m0_last = s_r.cfg.sync_baud_source ? sp_pkg::TICK_LAST : sp_pkg::M0_FIX_LAST;
  assign m0_half = s_r.cfg.sync_baud_source ? sp_pkg::M0_VAR_HALF : sp_pkg::M0_FIX_HALF;
  assign tx_last = s_r.cfg.mode[1] ? sp_pkg::FRAME_LAST9 : sp_pkg::FRAME_LAST8;
  assign rx_last = tx_last;

  // Bus and engine events
  assign wr          = s_r.ap_valid && s_r.ap_write;
  assign ctrl_wr     = wr && (s_r.ap_addr == sp_pkg::OFS_CTRL);
  assign buf_wr      = wr && (s_r.ap_addr == sp_pkg::OFS_BUF);
  assign ri_after_wr = ctrl_wr ? hwdata[sp_pkg::CTL_RI] : s_r.cfg.ri;
  assign tx_go       = buf_wr && (s_r.eng == sp_pkg::ENG_IDLE) && async_mode;
  assign tx_fin_ev   = ((s_r.eng == sp_pkg::ENG_ASYNC) && tx_tick &&
                        (s_r.tx_cnt == sp_pkg::TICK_LAST) && (s_r.tx_bit == tx_last)) ||
                       ((s_r.eng == sp_pkg::ENG_M0TX) && m0_tick &&
                        (s_r.tx_cnt == m0_last) && (s_r.tx_bit == sp_pkg::M0_BIT_LAST));
  assign m0rx_fin_ev = (s_r.eng == sp_pkg::ENG_M0RX) && m0_tick &&
                       (s_r.tx_cnt == m0_last) && (s_r.tx_bit == sp_pkg::M0_BIT_LAST);
  assign rx_stop_ev  = (s_r.rx == sp_pkg::RX_FRAME) && rx_tick &&
                       (s_r.rx_cnt == sp_pkg::SAMPLE_POINT) && (s_r.rx_bit == rx_last);
  assign rx_store    = rx_stop_ev && !ri_after_wr;
  assign rx_ninth    = s_r.rx_sh[8];

  always_comb begin
    s_nxt = s_r;
    // Address phase capture, read data prepared for the data phase
    s_nxt.ap_valid = hsel && htrans[1] && hready;
    s_nxt.ap_write = hwrite;
    s_nxt.ap_addr  = haddr[7:0];
    if (hsel && htrans[1] && hready && !hwrite) begin
      s_nxt.hrdata = reg_read(s_r, haddr[7:0]);
    end
    // Data phase writes
    if (ctrl_wr) begin
      s_nxt.cfg.mode = sp_pkg::sp_mode_t'(hwdata[sp_pkg::CTL_MHI:sp_pkg::CTL_MLO]);
      s_nxt.cfg.ren  = hwdata[sp_pkg::CTL_REN];
      s_nxt.cfg.tb8  = hwdata[sp_pkg::CTL_TB8];
      s_nxt.cfg.rb8  = hwdata[sp_pkg::CTL_RB8];
      s_nxt.cfg.ti   = hwdata[sp_pkg::CTL_TI];
      s_nxt.cfg.ri   = hwdata[sp_pkg::CTL_RI];
      s_nxt.cfg.fe   = hwdata[sp_pkg::CTL_FE];
      if ((hwdata[sp_pkg::CTL_MHI:sp_pkg::CTL_MLO] == 2'b00) && hwdata[sp_pkg::CTL_REN] &&
          !hwdata[sp_pkg::CTL_RI] && (s_r.eng == sp_pkg::ENG_IDLE)) begin
        s_nxt.eng    = sp_pkg::ENG_M0RX;
        s_nxt.tx_bit = 4'h0;
        s_nxt.tx_cnt = 4'h0;
      end
    end
    if (buf_wr && (s_r.eng == sp_pkg::ENG_IDLE)) begin
      s_nxt.tx_bit = 4'h0;
      s_nxt.tx_cnt = 4'h0;
      if (async_mode) begin
        s_nxt.eng   = sp_pkg::ENG_ASYNC;
        s_nxt.tx_sh = {1'b1, (s_r.cfg.mode[1] ? s_r.cfg.tb8 : 1'b1),
                       hwdata[7:0], 1'b0};
      end else begin
        s_nxt.eng   = sp_pkg::ENG_M0TX;
        s_nxt.tx_sh = {3'b111, hwdata[7:0]};
      end
    end
    if (wr && (s_r.ap_addr == sp_pkg::OFS_PWR)) begin
      s_nxt.cfg.dbl = hwdata[sp_pkg::PWR_DBL];
      s_nxt.cfg.fce = hwdata[sp_pkg::PWR_FCE];
    end
    if (wr && (s_r.ap_addr == sp_pkg::OFS_BDR)) begin
      s_nxt.cfg.sync_baud_source = hwdata[sp_pkg::BDR_SYNC_BAUD_SOURCE];
      s_nxt.cfg.prescale_bypass   = hwdata[sp_pkg::BDR_SPD];
      s_nxt.cfg.rbck  = hwdata[sp_pkg::BDR_RBCK];
      s_nxt.cfg.tbck  = hwdata[sp_pkg::BDR_TBCK];
      s_nxt.cfg.brr   = hwdata[sp_pkg::BDR_BRR];
    end
    if (wr && (s_r.ap_addr == sp_pkg::OFS_BRL)) begin
      s_nxt.cfg.baud_reload_value = hwdata[7:0];
    end
    // Transmit and mode 0 engine; hardware sets come after writes
    unique case (s_r.eng)
      sp_pkg::ENG_IDLE: begin
      end
      sp_pkg::ENG_ASYNC: begin
        if (tx_tick) begin
          s_nxt.tx_cnt = s_r.tx_cnt + 4'h1;
          if (s_r.tx_cnt == sp_pkg::TICK_LAST) begin
            s_nxt.tx_sh  = {1'b1, s_r.tx_sh[10:1]};
            s_nxt.tx_bit = s_r.tx_bit + 4'h1;
            if (s_r.tx_bit == tx_last) begin
              s_nxt.eng    = sp_pkg::ENG_IDLE;
              s_nxt.cfg.ti = 1'b1;
            end
          end
        end
      end
      sp_pkg::ENG_M0TX, sp_pkg::ENG_M0RX: begin
        if (m0_tick) begin
          s_nxt.tx_cnt = s_r.tx_cnt + 4'h1;
          if (s_r.tx_cnt == m0_last) begin
            s_nxt.tx_cnt = 4'h0;
            s_nxt.tx_bit = s_r.tx_bit + 4'h1;
            s_nxt.tx_sh  = {1'b1, s_r.tx_sh[10:1]};
            if (s_r.eng == sp_pkg::ENG_M0RX) begin
              s_nxt.rx_sh = {rxd_in, s_r.rx_sh[8:1]};
            end
            if (s_r.tx_bit == sp_pkg::M0_BIT_LAST) begin
              s_nxt.eng = sp_pkg::ENG_IDLE;
              if (s_r.eng == sp_pkg::ENG_M0RX) begin
                s_nxt.rxbuf  = {rxd_in, s_r.rx_sh[8:2]};
                s_nxt.cfg.ri = 1'b1;
              end else begin
                s_nxt.cfg.ti = 1'b1;
              end
            end
          end
        end
      end
    endcase
    // Asynchronous receiver, 16 ticks per bit, sampled mid-bit
    s_nxt.rx_prev = rxd_in;
    unique case (s_r.rx)
      sp_pkg::RX_IDLE: begin
        if (s_r.cfg.ren && async_mode && s_r.rx_prev && !rxd_in) begin
          s_nxt.rx     = sp_pkg::RX_FRAME;
          s_nxt.rx_cnt = 4'h0;
          s_nxt.rx_bit = 4'h0;
        end
      end
      sp_pkg::RX_FRAME: begin
        if (rx_tick) begin
          s_nxt.rx_cnt = s_r.rx_cnt + 4'h1;
          if (s_r.rx_cnt == sp_pkg::TICK_LAST) begin
            s_nxt.rx_bit = s_r.rx_bit + 4'h1;
          end
          if (s_r.rx_cnt == sp_pkg::SAMPLE_POINT) begin
            if ((s_r.rx_bit == 4'h0) && rxd_in) begin
              s_nxt.rx = sp_pkg::RX_IDLE;
            end else if (s_r.rx_bit == rx_last) begin
              s_nxt.rx = sp_pkg::RX_IDLE;
              if (rx_store) begin
                s_nxt.cfg.ri  = 1'b1;
                s_nxt.rxbuf   = s_r.cfg.mode[1] ? s_r.rx_sh[7:0] : s_r.rx_sh[8:1];
                s_nxt.cfg.rb8 = s_r.cfg.mode[1] ? s_r.rx_sh[8] : rxd_in;
              end
              if (s_r.cfg.fce && !rxd_in) begin
                s_nxt.cfg.fe = 1'b1;
              end
            end else if (s_r.rx_bit != 4'h0) begin
              s_nxt.rx_sh = {rxd_in, s_r.rx_sh[8:1]};
            end
          end
        end
      end
    endcase
    // Registered pin and bus outputs
    if ((s_r.eng == sp_pkg::ENG_M0TX) || (s_r.eng == sp_pkg::ENG_M0RX)) begin
      s_nxt.txd = (s_r.tx_cnt <= m0_half);
    end else if (s_r.eng == sp_pkg::ENG_ASYNC) begin
      s_nxt.txd = s_r.tx_sh[0];
    end else begin
      s_nxt.txd = 1'b1;
    end
    s_nxt.rxd_oe = !async_mode && (s_r.eng != sp_pkg::ENG_M0RX);
    s_nxt.rxd_o  = (s_r.eng == sp_pkg::ENG_M0TX) ? s_r.tx_sh[0] : 1'b1;
    s_nxt.irq    = s_r.cfg.ri || s_r.cfg.ti;
    s_nxt.hready = 1'b1;
    s_nxt.hresp  = 1'b0;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_r         <= '0;
      s_r.cfg.baud_reload_value <= sp_pkg::RST_BRL;
      s_r.rx_prev <= 1'b1;
      s_r.txd     <= 1'b1;
      s_r.rxd_o   <= 1'b1;
      s_r.rxd_oe  <= 1'b1;
      s_r.hready  <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign hreadyout  = s_r.hready;
  assign hresp      = s_r.hresp;
  assign hrdata     = s_r.hrdata;
  assign txd_out    = s_r.txd;
  assign rxd_out    = s_r.rxd_o;
  assign rxd_oe     = s_r.rxd_oe;
  assign serial_irq = s_r.irq;

  // Checks
  tx_done_set_a: assert property (@(posedge hclk) disable iff (!hresetn)
    tx_fin_ev |=> s_r.cfg.ti) else $error("transmit done flag not set");
  rx_done_set_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (rx_stop_ev || m0rx_fin_ev) |=> s_r.cfg.ri) else $error("receive done flag not set");
  fe_sticky_a: assert property (@(posedge hclk) disable iff (!hresetn)
    s_r.cfg.fe && !ctrl_wr |=> s_r.cfg.fe) else $error("framing error cleared by hardware");
  fe_set_a: assert property (@(posedge hclk) disable iff (!hresetn)
    rx_stop_ev && s_r.cfg.fce && !rxd_in |=> s_r.cfg.fe) else $error("framing error missed");
  fe_off_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !s_r.cfg.fce && !s_r.cfg.fe && !ctrl_wr |=> !s_r.cfg.fe) else $error("fe while disabled");
  brg_halt_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !s_r.cfg.brr |=> !brg_ovf) else $error("generator overflow while stopped");
  tx_start_a: assert property (@(posedge hclk) disable iff (!hresetn)
    tx_go |-> ##2 !txd_out) else $error("start bit not driven");
  idle_high_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (s_r.eng == sp_pkg::ENG_IDLE) && async_mode |=> txd_out) else $error("line not idle high");
  rb8_stop_a: assert property (@(posedge hclk) disable iff (!hresetn)
    rx_store && (s_r.cfg.mode == sp_pkg::MODE_UART8) |=> s_r.cfg.rb8 == $past(rxd_in))
    else $error("stop bit not stored");
  rb8_ninth_a: assert property (@(posedge hclk) disable iff (!hresetn)
    rx_store && s_r.cfg.mode[1] |=> s_r.cfg.rb8 == $past(rx_ninth))
    else $error("ninth bit not stored");
  m0_clock_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (s_r.eng == sp_pkg::ENG_M0TX) && (s_r.tx_cnt == 4'h0) |=> txd_out)
    else $error("shift clock not high first");
  mode2_rate_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (s_r.cfg.mode == sp_pkg::MODE_UART9F) && s_r.cfg.dbl |=> tx_tick)
    else $error("mode 2 doubled tick missing");

  m0_tx_c: cover property (@(posedge hclk) disable iff (!hresetn)
    tx_fin_ev && (s_r.eng == sp_pkg::ENG_M0TX));
  m0_rx_c: cover property (@(posedge hclk) disable iff (!hresetn) m0rx_fin_ev);
  async_rx_c: cover property (@(posedge hclk) disable iff (!hresetn) rx_store);
  fe_hit_c: cover property (@(posedge hclk) disable iff (!hresetn)
    rx_stop_ev && s_r.cfg.fce && !rxd_in);
endmodule : sp_uart

//--- sp_far.sv
// Far-side serial device: async frame sender and grabber, mode 0 shift register
`timescale 1ns/1ps
module sp_far (
  input  wire logic hclk,
  input  wire logic line_in,
  input  wire logic m0,
  output logic      line_out
);
  logic [7:0] sh;

  initial begin
    line_out = 1'b1;
    sh       = 8'h00;
  end

  // Drive one async frame, LSB first, then idle high
  task automatic send(input logic [10:0] bits, input int n, input int bc);
    for (int i = 0; i < n; i++) begin
      line_out <= bits[i];
      repeat (bc) @(posedge hclk);
    end
    line_out <= 1'b1;
  endtask : send

  // Wait for a start bit, then sample each bit at its centre
  task automatic grab(input int n, input int bc, output logic [10:0] bits);
    int k;
    k    = 0;
    bits = 11'h000;
    while (line_in !== 1'b0 && k < 4000) begin
      @(posedge hclk);
      k++;
    end
    repeat (bc / 2) @(posedge hclk);
    for (int i = 0; i < n; i++) begin
      bits[i] = line_in;
      repeat (bc) @(posedge hclk);
    end
  endtask : grab

  // Load shift register; first bit shown at once
  task automatic load(input logic [7:0] d);
    sh = d;
    line_out <= d[0];
  endtask : load

  // Next bit on each rising shift clock, filling with a changing pattern
  always @(posedge line_in) begin
    if (m0) begin
      sh = {~sh[0], sh[7:1]};
      line_out <= sh[0];
    end
  end
endmodule : sp_far

//--- tb_top.sv
// Register-level testbench of the serial port with a far-side device model
`timescale 1ns/1ps
module tb_top;
  logic        hclk    = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel    = 1'b0;
  logic [31:0] haddr   = 32'h0;
  logic [1:0]  htrans  = 2'h0;
  logic        hwrite  = 1'b0;
  logic [2:0]  hsize   = 3'h2;
  logic [31:0] hwdata  = 32'h0;
  logic        tmr_ovf = 1'b0;
  logic        m0      = 1'b0;
  logic        hreadyout, hresp, rxd_out, rxd_oe, txd_out, serial_irq, far_out;
  logic [31:0] hrdata, rd;
  logic [10:0] got;
  logic [7:0]  m0bits;
  int          bad_count = 0;
  int          n_checks  = 0;
  wire logic   rxd_line = rxd_oe ? rxd_out : far_out;

  always #5 hclk = ~hclk;
  always @(posedge hclk) tmr_ovf <= ~tmr_ovf;

  sp_uart i_sp_uart (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .rxd_in(rxd_line),
    .rxd_out(rxd_out), .rxd_oe(rxd_oe), .txd_out(txd_out), .tmr_ovf(tmr_ovf),
    .serial_irq(serial_irq));
  sp_far i_sp_far (.hclk(hclk), .line_in(txd_out), .m0(m0), .line_out(far_out));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    hwrite <= wr;
    htrans <= 2'h2;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hsel   <= 1'b0;
    hwdata <= wr ? wd : 32'h0;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask : ahb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    ahb(1'b1, a, d);
  endtask : wr

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    ahb(1'b0, a, 32'h0);
    check(rd, exp);
  endtask : rdchk

  task automatic m0cap();
    for (int i = 0; i < 8; i++) begin
      @(negedge txd_out);
      m0bits[i] = rxd_out;
    end
  endtask : m0cap

  task automatic final_report();
    $display("checks=%0d mismatches=%0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : final_report

  initial begin
    repeat (20000) @(posedge hclk);
    bad_count++;
    final_report();
  end

  initial begin
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    check({31'h0, txd_out}, 32'h1);
    rdchk(sp_pkg::OFS_CTRL, 32'h0);
    wr(8'h14, 32'h77);
    rdchk(8'h14, 32'h0);
    check({31'h0, hresp}, 32'h0);
    // Mode 2 send, doubled rate
    wr(sp_pkg::OFS_PWR, 32'hC0);
    wr(sp_pkg::OFS_CTRL, 32'h88);
    fork
      i_sp_far.grab(11, 16, got);
      wr(sp_pkg::OFS_BUF, 32'hA5);
    join
    check({21'h0, got}, 32'h74A);
    repeat (16) @(posedge hclk);
    rdchk(sp_pkg::OFS_CTRL, 32'h8A);
    check({31'h0, serial_irq}, 32'h1);
    // Mode 2 receive: bad stop, then good stop with error kept
    wr(sp_pkg::OFS_CTRL, 32'h90);
    i_sp_far.send(11'h2B4, 11, 16);
    rdchk(sp_pkg::OFS_CTRL, 32'h195);
    rdchk(sp_pkg::OFS_BUF, 32'h5A);
    wr(sp_pkg::OFS_CTRL, 32'h190);
    i_sp_far.send(11'h466, 11, 16);
    rdchk(sp_pkg::OFS_CTRL, 32'h191);
    rdchk(sp_pkg::OFS_BUF, 32'h33);
    wr(sp_pkg::OFS_PWR, 32'h80);
    wr(sp_pkg::OFS_CTRL, 32'h90);
    i_sp_far.send(11'h2B4, 11, 16);
    rdchk(sp_pkg::OFS_CTRL, 32'h95);
    // Mode 3 send from internal generator, no prescale
    wr(sp_pkg::OFS_BRL, 32'hFF);
    rdchk(sp_pkg::OFS_BRL, 32'hFF);
    wr(sp_pkg::OFS_BDR, 32'h1A);
    wr(sp_pkg::OFS_CTRL, 32'hC0);
    fork
      i_sp_far.grab(11, 16, got);
      wr(sp_pkg::OFS_BUF, 32'h81);
    join
    check({21'h0, got}, 32'h502);
    // Mode 1 receive from timer overflow, undoubled
    wr(sp_pkg::OFS_PWR, 32'h0);
    wr(sp_pkg::OFS_BDR, 32'h0);
    wr(sp_pkg::OFS_CTRL, 32'h50);
    i_sp_far.send(11'h386, 10, 64);
    rdchk(sp_pkg::OFS_CTRL, 32'h55);
    rdchk(sp_pkg::OFS_BUF, 32'hC3);
    // Mode 0 send, fixed rate
    wr(sp_pkg::OFS_CTRL, 32'h0);
    fork
      m0cap();
      wr(sp_pkg::OFS_BUF, 32'h3C);
    join
    check({24'h0, m0bits}, 32'h3C);
    repeat (6) @(posedge hclk);
    check({31'h0, rxd_out}, 32'h1);
    rdchk(sp_pkg::OFS_CTRL, 32'h2);
    // Mode 0 receive from the far shift register
    m0 <= 1'b1;
    i_sp_far.load(8'h96);
    wr(sp_pkg::OFS_CTRL, 32'h10);
    repeat (20) @(posedge hclk);
    check({31'h0, rxd_oe}, 32'h0);
    repeat (40) @(posedge hclk);
    rdchk(sp_pkg::OFS_CTRL, 32'h11);
    rdchk(sp_pkg::OFS_BUF, 32'h96);
    // Mode 0 send, variable rate from the generator
    wr(sp_pkg::OFS_BDR, 32'h13);
    fork
      m0cap();
      wr(sp_pkg::OFS_BUF, 32'h5A);
    join
    check({24'h0, m0bits}, 32'h5A);
    repeat (24) @(posedge hclk);
    rdchk(sp_pkg::OFS_CTRL, 32'h13);
    final_report();
  end
endmodule : tb_top
